// file: hw/flash_cmd_pkg.sv
// constants shared by the flash programming command interpreter
package flash_cmd_pkg;

  // ==========================================================
  // clock and link timing
  localparam int CLK_HZ = 100_000_000;
  localparam int DETECT_BPS = 9600;
  localparam int DETECT_LOW_BITS = 9;
  localparam logic [16:0] DEFAULT_BIT_CYCLES = 17'(CLK_HZ / DETECT_BPS);

  // ==========================================================
  // frame bytes
  localparam logic [7:0] HDR_CMD = 8'h01;
  localparam logic [7:0] HDR_DATA = 8'h02;
  localparam logic [7:0] FTR_END = 8'h03;
  localparam logic [7:0] BUSY_BYTE = 8'hFF;

  // ==========================================================
  // command numbers and lengths
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [7:0] CMD_BAUD = 8'h9A;
  localparam logic [7:0] CMD_OSC = 8'h90;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [8:0] LEN_BAUD = 9'h002;
  localparam logic [8:0] LEN_OSC = 9'h005;
  localparam logic [1:0] STAT_LEN_ONE = 2'h1;

  // ==========================================================
  // status codes
  localparam logic [7:0] ST_ACK = 8'h06;
  localparam logic [7:0] ST_CMD_ERR = 8'h04;
  localparam logic [7:0] ST_PARAM_ERR = 8'h05;
  localparam logic [7:0] ST_SUM_ERR = 8'h07;
  localparam logic [7:0] ST_FAIL = 8'h1A;

  // ==========================================================
  // oscillator and clock multiplier
  localparam logic [19:0] PLL_MULT = 20'h00008;
  localparam logic [16:0] OSC_RESET_KHZ = 17'h01F40;
  localparam logic [19:0] OSC_MIN_KHZ = 20'h0000A;
  localparam logic [19:0] OSC_MAX_KHZ = 20'h186A0;

  // ==========================================================
  // link modes
  localparam logic [1:0] MODE_UART = 2'h0;
  localparam logic [1:0] MODE_THREE_WIRE_HS = 2'h1;
  localparam logic [1:0] MODE_THREE_WIRE = 2'h2;

  // ==========================================================
  // register byte offsets
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_BAUD = 12'h008;
  localparam logic [11:0] REG_OSC = 12'h00C;
  localparam logic [11:0] REG_CPUCLK = 12'h010;
  localparam logic [11:0] REG_WIDTH = 12'h014;
  localparam logic [11:0] REG_BITCYC = 12'h018;

endpackage

// file: hw/low_width_meter.sv
// measures two low pulses on the receive line and averages them
`timescale 1ns/10ps
module low_width_meter import flash_cmd_pkg::*; (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic rxLine,
  output logic [16:0] avgWidth,
  output logic avgValid
);

  typedef struct packed {
    logic prev;
    logic [16:0] cnt;
    logic [17:0] sum;
    logic [1:0] seen;
    logic [16:0] avg;
    logic valid;
  } meter_s;

  meter_s m_q;
  meter_s m_d;

  // ==========================================================
  // pulse counting
  always_comb begin
    m_d = m_q;
    m_d.prev = rxLine;
    if (!rxLine && !m_q.valid) begin
      if (m_q.prev) begin
        m_d.cnt = 17'h00001;
      end else if (m_q.cnt != 17'h1FFFF) begin
        m_d.cnt = m_q.cnt + 17'h00001;
      end
    end
    if (rxLine && !m_q.prev && !m_q.valid) begin
      m_d.sum = m_q.sum + {1'b0, m_q.cnt};
      m_d.seen = m_q.seen + 2'h1;
      if (m_q.seen == 2'h1) begin
        m_d.avg = m_d.sum[17:1]; // R06
        m_d.valid = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      m_q <= '0;
      m_q.prev <= 1'b1;
    end else begin
      m_q <= m_d;
    end
  end

  assign avgWidth = m_q.avg;
  assign avgValid = m_q.valid;

  property p_avg_after_two;
    @(posedge clk_sys) disable iff (srst)
      $rose(m_q.valid) |-> m_q.seen == 2'h2;
  endproperty
  a_avg_after_two: assert property (p_avg_after_two) else $error("average taken too early"); // R06

endmodule

// file: hw/flash_cmd_interp.sv
// flash programming command interpreter with apb registers
`timescale 1ns/10ps
// Functional notes
// R01 - status frame length is chosen per answered command
// R02 - uart mode sends the status frame unprompted after every command
// R03 - status command in uart mode answers command number error
// R04 - reset command 00H, no parameters, answers one sync result byte
// R05 - reset answer carries one status byte with sync outcome
// R06 - baud detect: two 00H bytes at 9600, low widths averaged
// R07 - programmer issues reset after baud change to confirm sync
// R08 - baud set 9AH, length 02H, one rate byte, one-byte answer
// R09 - rate codes 03H..08H map to 9600..153600 bps
// R10 - baud set accepted in uart only, ignored in three-wire modes
// R11 - oscillator set 90H, length 05H, four parameter bytes
// R12 - three decimal digits of 0.1/0.01/0.001 times ten power, in kHz
// R13 - programmer keeps oscillator value within 10 kHz to 100 MHz
// R14 - cpu clock is eight times oscillator input from reset on
// R15 - oscillator set answers one byte with setting result
// R16 - chip erase 20H, no parameters, erases whole flash array
// R17 - chip erase also returns security settings to initial state
// R18 - chip erase answers one byte with erase outcome
// R19 - command frames 01H..03H, data frames 02H..03H
// R20 - checksum is zero minus length and following bytes, low 8 bits
// R21 - corrupted status command in three-wire mode returns busy FFH
// R22 - received checksum is recomputed and mismatch flagged
// R23 - unknown command numbers answer command number error
module flash_cmd_interp import flash_cmd_pkg::*; (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  output logic rxReady,
  input wire logic rxLine,
  output logic txValid,
  output logic [7:0] txData,
  input wire logic txReady,
  output logic [16:0] baudBitCycles,
  output logic [19:0] cpuClkKhz,
  output logic eraseReq,
  input wire logic flashDone,
  input wire logic flashFail,
  output logic securityReset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  typedef enum logic [3:0] {
    S_IDLE, S_LEN, S_COM, S_PARAM, S_SUM, S_FOOT, S_EXEC, S_ERASE, S_TX
  } state_e;

  typedef struct packed {
    state_e st;
    logic [1:0] mode;
    logic [8:0] cnt;
    logic [2:0] pIdx;
    logic [8:0] len;
    logic [7:0] command_number_field;
    logic [3:0][7:0] par;
    logic [7:0] sum;
    logic sumBad;
    logic synced;
    logic [7:0] stCmd;
    logic [7:0] stByte;
    logic [1:0] stLen;
    logic stValid;
    logic busyOnly;
    logic [2:0] txIdx;
    logic txValid;
    logic [7:0] txData;
    logic [16:0] oscKhz;
    logic [17:0] baudBps;
    logic [16:0] bitCycles;
    logic eraseReq;
    logic secClr;
    logic [31:0] prdata;
    logic pslverr;
  } ctl_s;

  ctl_s r_q;
  ctl_s r_d;
  logic [16:0] avgWidth;
  logic avgValid;
  logic rxTake;
  logic apbWrite;
  logic [19:0] oscCalc;
  logic [34:0] baudSel;

  // ==========================================================
  // helpers
  function automatic logic [1:0] statusLen(input logic [7:0] cmd);
    case (cmd)
      CMD_RESET, CMD_BAUD, CMD_OSC, CMD_ERASE: statusLen = STAT_LEN_ONE;
      default: statusLen = STAT_LEN_ONE;
    endcase
  endfunction

  // rate code to {bps, clock cycles per bit}, zero when invalid
  function automatic logic [34:0] baudOf(input logic [7:0] code);
    case (code)
      8'h03: baudOf = {18'h02580, 17'(CLK_HZ / 9600)};
      8'h04: baudOf = {18'h04B00, 17'(CLK_HZ / 19200)};
      8'h05: baudOf = {18'h07A12, 17'(CLK_HZ / 31250)};
      8'h06: baudOf = {18'h09600, 17'(CLK_HZ / 38400)};
      8'h07: baudOf = {18'h12C00, 17'(CLK_HZ / 76800)};
      8'h08: baudOf = {18'h25800, 17'(CLK_HZ / 153600)};
      default: baudOf = '0;
    endcase
  endfunction

  // digits d1..d3 weigh 0.1/0.01/0.001, e is the power of ten; result kHz
  function automatic logic [19:0] oscOf(input logic [3:0][7:0] p);
    logic [19:0] m;
    m = 20'(p[0]) * 20'h00064 + 20'(p[1]) * 20'h0000A + 20'(p[2]);
    if (p[0] > 8'h09 || p[1] > 8'h09 || p[2] > 8'h09) begin
      oscOf = '0;
    end else begin
      case (p[3])
        8'h01: oscOf = m / 20'h00064;
        8'h02: oscOf = m / 20'h0000A;
        8'h03: oscOf = m;
        8'h04: oscOf = m * 20'h0000A;
        8'h05: oscOf = m * 20'h00064;
        8'h06: oscOf = m * 20'h003E8;
        default: oscOf = '0;
      endcase
    end
  endfunction

  // byte idx of the outgoing status frame
  function automatic logic [7:0] frameByte(input logic [2:0] idx, input logic [7:0] st);
    case (idx)
      3'h0: frameByte = HDR_DATA;
      3'h1: frameByte = 8'(STAT_LEN_ONE);
      3'h2: frameByte = st;
      3'h3: frameByte = 8'h00 - 8'(STAT_LEN_ONE) - st;
      default: frameByte = FTR_END;
    endcase
  endfunction

  low_width_meter u_meter (
    .clk_sys(clk_sys),
    .srst(srst),
    .rxLine(rxLine),
    .avgWidth(avgWidth),
    .avgValid(avgValid)
  );

  assign rxReady = (r_q.st == S_IDLE) || (r_q.st == S_LEN) || (r_q.st == S_COM) ||
                   (r_q.st == S_PARAM) || (r_q.st == S_SUM) || (r_q.st == S_FOOT);
  assign rxTake = rxValid && rxReady;
  assign apbWrite = psel && penable && pwrite;
  assign oscCalc = oscOf(r_q.par);
  assign baudSel = baudOf(r_q.par[0]);

  // ==========================================================
  // next state
  always_comb begin
    r_d = r_q;
    r_d.secClr = 1'b0;
    // measured timing applies only at the detection rate, also replacing a baud set to that rate
    if (avgValid && !r_q.synced && r_q.mode == MODE_UART && r_q.baudBps == 18'(DETECT_BPS)) begin
      r_d.bitCycles = 17'(avgWidth / 17'(DETECT_LOW_BITS)); // R06
      r_d.baudBps = 18'(DETECT_BPS);
    end
    case (r_q.st)
      S_IDLE: begin
        if (rxTake && rxData == HDR_CMD) begin // R19
          r_d.st = S_LEN;
        end
      end
      S_LEN: begin
        if (rxTake) begin
          r_d.len = (rxData == 8'h00) ? 9'h100 : {1'b0, rxData};
          r_d.cnt = r_d.len;
          r_d.sum = 8'h00 - rxData; // R20
          r_d.pIdx = '0;
          r_d.st = S_COM;
        end
      end
      S_COM: begin
        if (rxTake) begin
          r_d.command_number_field = rxData;
          r_d.sum = r_q.sum - rxData; // R20
          r_d.cnt = r_q.cnt - 9'h001;
          r_d.st = (r_q.cnt == 9'h001) ? S_SUM : S_PARAM;
        end
      end
      S_PARAM: begin
        if (rxTake) begin
          if (r_q.pIdx < 3'h4) begin
            r_d.par[r_q.pIdx[1:0]] = rxData;
            r_d.pIdx = r_q.pIdx + 3'h1;
          end
          r_d.sum = r_q.sum - rxData; // R20
          r_d.cnt = r_q.cnt - 9'h001;
          if (r_q.cnt == 9'h001) begin
            r_d.st = S_SUM;
          end
        end
      end
      S_SUM: begin
        if (rxTake) begin
          r_d.sumBad = (rxData != r_q.sum); // R22
          r_d.st = S_FOOT;
        end
      end
      S_FOOT: begin
        if (rxTake) begin
          r_d.sumBad = r_q.sumBad || (rxData != FTR_END); // R19
          r_d.st = S_EXEC;
        end
      end
      S_EXEC: begin
        r_d.stCmd = r_q.command_number_field;
        r_d.stLen = statusLen(r_q.command_number_field); // R01
        r_d.stValid = 1'b1;
        r_d.busyOnly = 1'b0;
        r_d.txIdx = '0;
        r_d.st = (r_q.mode == MODE_UART) ? S_TX : S_IDLE; // R02
        if (r_q.command_number_field == CMD_STATUS) begin
          r_d.stCmd = r_q.stCmd;
          r_d.stLen = r_q.stLen;
          if (r_q.mode == MODE_UART) begin
            r_d.stByte = ST_CMD_ERR; // R03
          end else if (r_q.sumBad) begin
            r_d.busyOnly = 1'b1; // R21
            r_d.st = S_TX;
          end else begin
            r_d.st = S_TX;
          end
        end else if (r_q.sumBad) begin
          r_d.stByte = ST_SUM_ERR; // R22
        end else begin
          case (r_q.command_number_field)
            CMD_RESET: begin
              r_d.synced = (r_q.mode != MODE_UART) || avgValid; // R04
              r_d.stByte = r_d.synced ? ST_ACK : ST_FAIL; // R05
            end
            CMD_BAUD: begin
              if (r_q.mode != MODE_UART) begin
                r_d = r_q; // R10
                r_d.st = S_IDLE;
              end else if (r_q.len != LEN_BAUD || baudSel == '0) begin
                r_d.stByte = ST_PARAM_ERR;
              end else begin
                r_d.baudBps = baudSel[34:17]; // R09
                r_d.bitCycles = baudSel[16:0]; // R08
                r_d.synced = 1'b0;
                r_d.stByte = ST_ACK;
              end
            end
            CMD_OSC: begin
              if (r_q.len != LEN_OSC || oscCalc < OSC_MIN_KHZ || oscCalc > OSC_MAX_KHZ) begin
                r_d.stByte = ST_PARAM_ERR; // R13
              end else begin
                r_d.oscKhz = oscCalc[16:0]; // R12
                r_d.stByte = ST_ACK; // R15
              end
            end
            CMD_ERASE: begin
              r_d.eraseReq = 1'b1; // R16
              r_d.st = S_ERASE;
            end
            default: r_d.stByte = ST_CMD_ERR; // R23
          endcase
        end
      end
      S_ERASE: begin
        if (flashDone) begin
          r_d.eraseReq = 1'b0;
          r_d.secClr = !flashFail; // R17
          r_d.stByte = flashFail ? ST_FAIL : ST_ACK; // R18
          r_d.st = (r_q.mode == MODE_UART) ? S_TX : S_IDLE;
        end
      end
      S_TX: begin
        if (!r_q.txValid) begin
          r_d.txValid = 1'b1;
          r_d.txData = r_q.busyOnly ? BUSY_BYTE : frameByte(r_q.txIdx, r_q.stByte);
        end else if (txReady) begin
          r_d.txValid = 1'b0;
          r_d.txIdx = r_q.txIdx + 3'h1;
          if (r_q.busyOnly || r_q.txIdx == 3'h4) begin
            r_d.st = S_IDLE;
          end
        end
      end
      default: r_d.st = S_IDLE;
    endcase
    // apb register access
    if (psel && !penable) begin
      r_d.pslverr = 1'b0;
      case (paddr)
        REG_CTRL: r_d.prdata = {30'h0, r_q.mode};
        REG_STATUS: r_d.prdata = {12'h0, r_q.stValid, r_q.synced, r_q.stLen,
                                 r_q.stCmd, r_q.stByte};
        REG_BAUD: r_d.prdata = {14'h0, r_q.baudBps};
        REG_OSC: r_d.prdata = {15'h0, r_q.oscKhz};
        REG_CPUCLK: r_d.prdata = {12'h0, cpuClkKhz};
        REG_WIDTH: r_d.prdata = {14'h0, avgValid, avgWidth};
        REG_BITCYC: r_d.prdata = {15'h0, r_q.bitCycles};
        default: begin
          r_d.prdata = 32'h00000000;
          r_d.pslverr = 1'b1;
        end
      endcase
    end
    if (apbWrite && paddr == REG_CTRL) begin
      r_d.mode = pwdata[1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      r_q <= '0;
      r_q.st <= S_IDLE;
      r_q.mode <= MODE_UART;
      r_q.oscKhz <= OSC_RESET_KHZ;
      r_q.baudBps <= 18'(DETECT_BPS);
      r_q.bitCycles <= DEFAULT_BIT_CYCLES;
    end else begin
      r_q <= r_d;
    end
  end

  // ==========================================================
  // outputs
  assign txValid = r_q.txValid;
  assign txData = r_q.txData;
  assign baudBitCycles = r_q.bitCycles;
  assign cpuClkKhz = 20'(r_q.oscKhz) * PLL_MULT; // R14
  assign eraseReq = r_q.eraseReq;
  assign securityReset = r_q.secClr;
  assign prdata = r_q.prdata;
  assign pready = psel && penable;
  assign pslverr = psel && penable && r_q.pslverr;

  // ==========================================================
  // checks
  property p_tx_hold;
    @(posedge clk_sys) disable iff (srst)
      txValid && !txReady |=> txValid && $stable(txData);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx byte dropped"); // R02

  property p_status_uart;
    @(posedge clk_sys) disable iff (srst)
      r_q.st == S_EXEC && r_q.command_number_field == CMD_STATUS && r_q.mode == MODE_UART
      |=> r_q.stByte == ST_CMD_ERR && r_q.st == S_TX;
  endproperty
  a_status_uart: assert property (p_status_uart) else $error("uart status not refused"); // R03

  property p_baud_ignore;
    @(posedge clk_sys) disable iff (srst)
      r_q.st == S_EXEC && r_q.command_number_field == CMD_BAUD && r_q.mode != MODE_UART && !r_q.sumBad
      |=> r_q.st == S_IDLE && $stable(r_q.bitCycles) && $stable(r_q.stByte);
  endproperty
  a_baud_ignore: assert property (p_baud_ignore) else $error("baud set not ignored"); // R10

  property p_pll_reset;
    @(posedge clk_sys) srst |=> cpuClkKhz == 20'(OSC_RESET_KHZ) * PLL_MULT;
  endproperty
  a_pll_reset: assert property (p_pll_reset) else $error("cpu clock not x8 at reset"); // R14

  property p_sum_check;
    @(posedge clk_sys) disable iff (srst)
      r_q.st == S_SUM && rxTake |=> r_q.sumBad == ($past(rxData) != $past(r_q.sum));
  endproperty
  a_sum_check: assert property (p_sum_check) else $error("checksum compare wrong"); // R22

  property p_busy;
    @(posedge clk_sys) disable iff (srst)
      r_q.st == S_EXEC && r_q.command_number_field == CMD_STATUS && r_q.mode != MODE_UART && r_q.sumBad
      |=> r_q.st == S_TX ##1 txValid && txData == BUSY_BYTE;
  endproperty
  a_busy: assert property (p_busy) else $error("busy byte not sent"); // R21

  property p_unknown;
    @(posedge clk_sys) disable iff (srst)
      r_q.st == S_EXEC && !r_q.sumBad && r_q.command_number_field != CMD_STATUS && r_q.command_number_field != CMD_RESET &&
      r_q.command_number_field != CMD_BAUD && r_q.command_number_field != CMD_OSC && r_q.command_number_field != CMD_ERASE
      |=> r_q.stByte == ST_CMD_ERR && !eraseReq;
  endproperty
  a_unknown: assert property (p_unknown) else $error("unknown command executed"); // R23

  property p_frame_head;
    @(posedge clk_sys) disable iff (srst)
      r_q.st == S_TX && !r_q.busyOnly && r_q.txIdx == 3'h0 && txValid |-> txData == HDR_DATA;
  endproperty
  a_frame_head: assert property (p_frame_head) else $error("status frame header wrong"); // R19

  property p_erase;
    @(posedge clk_sys) disable iff (srst)
      r_q.st == S_EXEC && r_q.command_number_field == CMD_ERASE && !r_q.sumBad |=> eraseReq;
  endproperty
  a_erase: assert property (p_erase) else $error("erase not requested"); // R16

  property p_sec_clear;
    @(posedge clk_sys) disable iff (srst)
      securityReset |-> $past(eraseReq) && !eraseReq && r_q.stByte == ST_ACK;
  endproperty
  a_sec_clear: assert property (p_sec_clear) else $error("security reset without erase"); // R17

endmodule

// file: bench/flash_programmer_model.sv
// programmer-side model: sends command frames and collects status bytes
`timescale 1ns/10ps
module flash_programmer_model (
  input wire logic clk_sys,
  input wire logic rxReady,
  input wire logic txValid,
  input wire logic [7:0] txData,
  output logic rxValid,
  output logic [7:0] rxData,
  output logic rxLine,
  output logic txReady
);
  logic [7:0] got[$];

  initial begin
    rxValid = 1'b0;
    rxData = 8'h00;
    rxLine = 1'b1;
    txReady = 1'b0;
  end

  // ==========================================================
  // status byte sink, stalls at random
  always @(posedge clk_sys) begin
    if (txValid && txReady) begin
      got.push_back(txData);
    end
    txReady <= ($urandom % 3) != 0;
  end

  // ==========================================================
  // byte offer held until taken; the data line then shows the inverse
  task automatic send_byte(input logic [7:0] b);
    int n;
    n = 0;
    @(posedge clk_sys);
    rxValid <= 1'b1;
    rxData <= b;
    do begin
      @(posedge clk_sys);
      n++;
    end while (rxReady !== 1'b1 && n < 1000);
    rxValid <= 1'b0;
    rxData <= ~b;
  endtask

  task automatic send_frame(input logic [7:0] command_number_field, input int np, input logic [31:0] prm,
      input logic [7:0] flip);
    logic [7:0] len;
    logic [7:0] sum;
    len = 8'(np + 1);
    sum = 8'h00 - len - command_number_field;
    send_byte(8'h01);
    send_byte(len);
    send_byte(command_number_field);
    for (int i = 0; i < np; i++) begin
      send_byte(prm[31 - 8 * i -: 8]);
      sum = sum - prm[31 - 8 * i -: 8];
    end
    send_byte(sum ^ flip);
    send_byte(8'h03);
  endtask

  // one low pulse standing in for a 00H byte: start bit plus eight zeros
  task automatic pulse_low(input int w);
    @(posedge clk_sys);
    rxLine <= 1'b0;
    repeat (w) @(posedge clk_sys);
    rxLine <= 1'b1;
    repeat (50) @(posedge clk_sys);
  endtask
endmodule

// file: bench/test_flash_prog_setup_commands.sv
// self-checking bench for the flash programming command interpreter
`timescale 1ns/10ps
module test_flash_prog_setup_commands import flash_cmd_pkg::*;;
  logic clk_sys, srst, rxValid, rxReady, rxLine, txValid, txReady;
  logic [7:0] rxData, txData;
  logic [16:0] baudBitCycles;
  logic [19:0] cpuClkKhz;
  logic eraseReq, flashDone, flashFail, securityReset;
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  int n_fail, checked, cyc;

  flash_cmd_interp uut (.clk_sys(clk_sys), .srst(srst), .rxValid(rxValid), .rxData(rxData),
    .rxReady(rxReady), .rxLine(rxLine), .txValid(txValid), .txData(txData),
    .txReady(txReady), .baudBitCycles(baudBitCycles), .cpuClkKhz(cpuClkKhz),
    .eraseReq(eraseReq), .flashDone(flashDone), .flashFail(flashFail),
    .securityReset(securityReset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  flash_programmer_model prog (.clk_sys(clk_sys), .rxReady(rxReady), .txValid(txValid),
    .txData(txData), .rxValid(rxValid), .rxData(rxData), .rxLine(rxLine), .txReady(txReady));

  always #5 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end

  // ==========================================================
  // checking and expectations
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  function automatic logic [7:0] fsum(input logic [7:0] st);
    return 8'h00 - 8'h01 - st;
  endfunction

  function automatic logic [31:0] bps(input int c);
    case (c)
      3: return 32'h2580;
      4: return 32'h4B00;
      5: return 32'h7A12;
      6: return 32'h9600;
      7: return 32'h12C00;
      default: return 32'h25800;
    endcase
  endfunction

  function automatic logic [31:0] osc_khz(input int a, input int b, input int c, input int x);
    longint v;
    v = a * 100 + b * 10 + c;
    repeat (x) v = v * 10;
    return 32'(v / 1000);
  endfunction

  task automatic wait_bytes(input int k);
    int n;
    n = 0;
    while (prog.got.size() < k && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    repeat (20) @(posedge clk_sys);
  endtask

  task automatic expect_frame(input logic [7:0] st);
    wait_bytes(5);
    chk("frame size", 32'(prog.got.size()), 32'h5);
    if (prog.got.size() == 5) begin
      chk("header", prog.got[0], 8'h02);
      chk("length", prog.got[1], 8'h01);
      chk("status", prog.got[2], st);
      chk("checksum", prog.got[3], fsum(st));
      chk("footer", prog.got[4], 8'h03);
    end
    prog.got.delete();
  endtask

  task automatic expect_none();
    repeat (200) @(posedge clk_sys);
    chk("silent", 32'(prog.got.size()), 32'h0);
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 100);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] rd;
    logic err;
    int d1, d2, d3, e, n;
    clk_sys = 1'b0;
    srst = 1'b1;
    flashDone = 1'b0;
    flashFail = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    void'($urandom(1839));
    repeat (8) @(posedge clk_sys);
    srst <= 1'b0;
    chk("bit cycles", baudBitCycles, 32'h28B0);
    chk("cpu clock", cpuClkKhz, 32'hFA00);
    prog.send_frame(CMD_RESET, 0, 32'h0, 8'h00);
    expect_frame(ST_FAIL);
    prog.pulse_low(908);
    prog.pulse_low(918);
    prog.send_frame(CMD_RESET, 0, 32'h0, 8'h00);
    expect_frame(ST_ACK);
    chk("bit cycles", baudBitCycles, 32'h65);
    $display("test sync done");
    prog.send_frame(CMD_STATUS, 0, 32'h0, 8'h00);
    expect_frame(ST_CMD_ERR);
    prog.send_frame(8'h55, 0, 32'h0, 8'h00);
    expect_frame(ST_CMD_ERR);
    prog.send_frame(CMD_ERASE, 0, 32'h0, 8'h10);
    expect_frame(ST_SUM_ERR);
    chk("erase request", eraseReq, 32'h0);
    $display("test refusals done");
    for (int c = 3; c <= 9; c++) begin
      prog.send_frame(CMD_BAUD, 1, {8'(c), 24'h0}, 8'h00);
      expect_frame(c == 9 ? ST_PARAM_ERR : ST_ACK);
      apb(1'b0, REG_BAUD, 32'h0, rd, err);
      chk("baud", rd, bps(c));
      prog.send_frame(CMD_RESET, 0, 32'h0, 8'h00);
      expect_frame(ST_ACK);
    end
    $display("test baud done");
    prog.send_frame(CMD_OSC, 4, 32'h01000006, 8'h00);
    expect_frame(ST_ACK);
    chk("cpu clock", cpuClkKhz, 32'hC3500);
    prog.send_frame(CMD_OSC, 4, 32'h0A000004, 8'h00);
    expect_frame(ST_PARAM_ERR);
    repeat (4) begin
      d1 = $urandom_range(1, 9);
      d2 = $urandom_range(0, 9);
      d3 = $urandom_range(0, 9);
      e = $urandom_range(3, 5);
      prog.send_frame(CMD_OSC, 4, {8'(d1), 8'(d2), 8'(d3), 8'(e)}, 8'h00);
      expect_frame(ST_ACK);
      chk("cpu clock", cpuClkKhz, osc_khz(d1, d2, d3, e) * 8);
    end
    $display("test oscillator done");
    for (int f = 0; f < 2; f++) begin
      prog.send_frame(CMD_ERASE, 0, 32'h0, 8'h00);
      n = 0;
      while (eraseReq !== 1'b1 && n < 200) begin
        @(posedge clk_sys);
        n++;
      end
      chk("erase request", eraseReq, 32'h1);
      repeat (5) @(posedge clk_sys);
      flashDone <= 1'b1;
      flashFail <= f[0];
      @(posedge clk_sys);
      flashDone <= 1'b0;
      flashFail <= 1'b0;
      @(posedge clk_sys);
      chk("security reset", securityReset, !f[0]);
      chk("erase request", eraseReq, 32'h0);
      expect_frame(f[0] ? ST_FAIL : ST_ACK);
    end
    $display("test erase done");
    for (int m = 1; m <= 2; m++) begin
      apb(1'b1, REG_CTRL, 32'(m), rd, err);
      apb(1'b0, REG_CTRL, 32'h0, rd, err);
      chk("mode", rd[1:0], 32'(m));
      prog.send_frame(CMD_OSC, 4, 32'h08000004, 8'h00);
      expect_none();
      chk("cpu clock", cpuClkKhz, 32'hFA00);
      prog.send_frame(CMD_BAUD, 1, 32'h04000000, 8'h00);
      expect_none();
      apb(1'b0, REG_BAUD, 32'h0, rd, err);
      chk("baud", rd, 32'h25800);
      prog.send_frame(CMD_STATUS, 0, 32'h0, 8'h00);
      expect_frame(ST_ACK);
      prog.send_frame(CMD_STATUS, 0, 32'h0, 8'h01);
      wait_bytes(1);
      chk("busy size", 32'(prog.got.size()), 32'h1);
      chk("busy", prog.got.size() > 0 ? prog.got[0] : 8'h00, BUSY_BYTE);
      prog.got.delete();
    end
    $display("test three-wire done");
    apb(1'b0, 12'h100, 32'h0, rd, err);
    chk("slave error", err, 32'h1);
    chk("read data", rd, 32'h0);
    $display("test bus done");
    end_sim();
  end
endmodule
